// >>> rtl/fsr_pkg.sv
// Constants, register map and carrier types of the fan-speed regulator core.
// Assumes a 25 MHz system clock; the register map is reached over AXI4-Lite.
package fsr_pkg;

    // register byte offsets
    localparam logic [7:0] REG_SPEED = 8'h00;
    localparam logic [7:0] REG_CONFIG = 8'h04;
    localparam logic [7:0] REG_DAC = 8'h08;
    localparam logic [7:0] REG_GPIO_DEF = 8'h0c;
    localparam logic [7:0] REG_GPIO_STATUS = 8'h10;
    localparam logic [7:0] REG_COUNT_TIME = 8'h14;
    localparam logic [7:0] REG_TACH = 8'h18;
    localparam logic [7:0] REG_ALARM_EN = 8'h1c;
    localparam logic [7:0] REG_ALARM_STATUS = 8'h20;
    localparam logic [7:0] REG_DRIVE = 8'h24;

    // reset values
    localparam logic [7:0] RST_SPEED = 8'h00;
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RST_DAC = 8'h00;
    localparam logic [7:0] RST_GPIO_DEF = 8'hff;
    localparam logic [1:0] RST_COUNT_TIME = 2'h3;

    // field positions
    localparam int ALARM_OVF_BIT = 2;
    localparam int NUM_PINS = 5;
    localparam int NUM_PINS_SINGLE = 2;
    localparam int NUM_PAIR_PINS = 3;

    // drive levels: low code is full fan voltage
    localparam logic [7:0] DRIVE_FULL_ON = 8'h00;
    localparam logic [7:0] DRIVE_FULL_OFF = 8'hff;
    localparam logic [7:0] TACH_MAX = 8'hff;

    // timing: figures in their own units, cycle counts derived
    localparam int CLK_HZ = 25000000;
    localparam int OSC_HZ = 254000;
    localparam int OSC_DIV_CYC = CLK_HZ / OSC_HZ;
    localparam logic [6:0] OSC_PER_BASE_M1 = 7'h7f;
    localparam int COUNT_BASE_MS = 250;
    localparam int COUNT_BASE_CYC = (CLK_HZ / 1000) * COUNT_BASE_MS;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        FSR_FULL_ON = 2'b00,
        FSR_FULL_OFF = 2'b01,
        FSR_CLOSED = 2'b10,
        FSR_OPEN = 2'b11
    } fsr_mode_t;

    typedef struct packed {
        logic [1:0] spare;
        fsr_mode_t mode;
        logic fan_12v;
        logic [2:0] prescale;
    } fsr_cfg_t;

    typedef struct packed {
        logic pin_four;
        logic pin_three;
        logic [1:0] pin_two;
        logic [1:0] pin_one;
        logic [1:0] pin_zero;
    } fsr_gpio_def_t;

endpackage : fsr_pkg

// >>> rtl/fsr_core.sv
// Fan-speed regulator core: AXI4-Lite registers, reference divider, closed
// loop, tach counter and open-drain general pins.
// Assumes tach and pin levels arrive asynchronously; the pad resolves the
// open-drain wire from general_pin_oe with general_pin_drive held low.
`timescale 1ns/1ps
module fsr_core #(
    parameter int OSC_DIV = fsr_pkg::OSC_DIV_CYC,
    parameter int COUNT_BASE = fsr_pkg::COUNT_BASE_CYC,
    parameter bit MULTI_TACH = 1'b1
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // fan
    input wire logic primary_tach_input,
    output logic [7:0] fan_drive,
    output logic tach_overflow_alert,
    // general pins, open drain
    input wire logic [4:0] general_pin_level,
    output logic [4:0] general_pin_drive,
    output logic [4:0] general_pin_oe
);

    // registers
    logic [7:0] speed, dac, tach_reg;
    fsr_pkg::fsr_cfg_t cfg;
    fsr_pkg::fsr_gpio_def_t gpio_def;
    logic [1:0] count_time;
    logic alarm_en_ovf, ovf_flag;
    // axi slave state
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire, wr_lane, wr_hit, rd_fire;
    // synchronisers
    logic [1:0] tach_sync;
    logic tach_prev, tach_rise;
    logic [4:0] pin_meta, pin_sync, pin_present;
    // reference path
    logic [6:0] osc_cnt, base_cnt;
    logic osc_tick, base_tick, ref_tick;
    logic [7:0] ref_cnt;
    // loop
    logic [3:0] pre_cnt, pre_max;
    logic div_edge, div_seen, fast;
    logic [7:0] loop_drive, next_drive;
    // tach counter
    logic [31:0] ivl_cnt, ivl_len;
    logic ivl_end, ovf_set, ovf_clr;
    logic [7:0] tach_cnt, next_tach;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ---- axi4-lite slave: one write and one read in flight at most
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign wr_lane = wr_fire && w_strb[0];
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    // the map is dense and aw_addr is word aligned, so one compare covers it
    assign wr_hit = (aw_addr <= fsr_pkg::REG_DRIVE);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[7:2], 2'b00};
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= fsr_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? fsr_pkg::RESP_OKAY : fsr_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // host-written registers; read-only offsets take the write and ignore it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            speed <= fsr_pkg::RST_SPEED;
            cfg <= fsr_pkg::RST_CONFIG;
            dac <= fsr_pkg::RST_DAC;
            gpio_def <= fsr_pkg::RST_GPIO_DEF;
            count_time <= fsr_pkg::RST_COUNT_TIME;
            alarm_en_ovf <= 1'b0;
        end else if (wr_lane) begin
            case (aw_addr)
                fsr_pkg::REG_SPEED: speed <= w_data[7:0];
                fsr_pkg::REG_CONFIG: cfg <= w_data[7:0];
                fsr_pkg::REG_DAC: dac <= w_data[7:0];
                fsr_pkg::REG_GPIO_DEF: gpio_def <= w_data[7:0];
                fsr_pkg::REG_COUNT_TIME: count_time <= w_data[1:0];
                fsr_pkg::REG_ALARM_EN: alarm_en_ovf <= w_data[fsr_pkg::ALARM_OVF_BIT];
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= fsr_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= fsr_pkg::RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
                fsr_pkg::REG_SPEED: s_axi_rdata <= {24'h000000, speed};
                fsr_pkg::REG_CONFIG: s_axi_rdata <= {24'h000000, cfg};
                fsr_pkg::REG_DAC: s_axi_rdata <= {24'h000000, dac};
                fsr_pkg::REG_GPIO_DEF: s_axi_rdata <= {24'h000000, gpio_def};
                fsr_pkg::REG_GPIO_STATUS: s_axi_rdata <= {27'h0000000, pin_sync & pin_present};
                fsr_pkg::REG_COUNT_TIME: s_axi_rdata <= {30'h00000000, count_time};
                fsr_pkg::REG_TACH: s_axi_rdata <= {24'h000000, tach_reg};
                fsr_pkg::REG_ALARM_EN: s_axi_rdata <= {29'h00000000, alarm_en_ovf, 2'b00};
                fsr_pkg::REG_ALARM_STATUS: s_axi_rdata <= {29'h00000000, ovf_flag, 2'b00};
                fsr_pkg::REG_DRIVE: s_axi_rdata <= {24'h000000, fan_drive};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= fsr_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---- input synchronisers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tach_sync <= 2'b00;
            tach_prev <= 1'b0;
            pin_meta <= 5'h1f;
            pin_sync <= 5'h1f;
        end else begin
            tach_sync <= {tach_sync[0], primary_tach_input};
            tach_prev <= tach_sync[1];
            pin_meta <= general_pin_level;
            pin_sync <= pin_meta;
        end
    end

    assign tach_rise = tach_sync[1] && !tach_prev;

    // ---- reference: oscillator tick, /128 base tick, /(speed+1) reference
    assign osc_tick = (osc_cnt == 7'(OSC_DIV - 1));
    assign base_tick = osc_tick && (base_cnt == fsr_pkg::OSC_PER_BASE_M1);
    assign ref_tick = base_tick && (ref_cnt >= speed);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_cnt <= 7'h00;
            base_cnt <= 7'h00;
        end else begin
            osc_cnt <= osc_tick ? 7'h00 : osc_cnt + 7'h01;
            if (osc_tick) begin
                base_cnt <= base_cnt + 7'h01; // wraps after 128 ticks
            end
        end
    end

    // a setpoint lowered below the running count ends the period at the next base tick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_cnt <= 8'h00;
        end else if (ref_tick) begin
            ref_cnt <= 8'h00;
        end else if (base_tick) begin
            ref_cnt <= ref_cnt + 8'h01;
        end
    end

    // ---- tach prescaler, only in the loop path
    always_comb begin
        case (cfg.prescale)
            3'h0: pre_max = 4'h0;
            3'h1: pre_max = 4'h1;
            3'h2: pre_max = 4'h3;
            3'h3: pre_max = 4'h7;
            default: pre_max = 4'hf;
        endcase
    end

    assign div_edge = tach_rise && (pre_cnt >= pre_max);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_cnt <= 4'h0;
        end else if (div_edge) begin
            pre_cnt <= 4'h0;
        end else if (tach_rise) begin
            pre_cnt <= pre_cnt + 4'h1;
        end
    end

    // an edge in the comparison cycle counts for the period it ends
    assign fast = div_seen || div_edge;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_seen <= 1'b0;
        end else begin
            div_seen <= !ref_tick && fast;
        end
    end

    // ---- closed loop: raising drive means lowering the code
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            loop_drive <= fsr_pkg::DRIVE_FULL_ON;
        end else if (cfg.mode != fsr_pkg::FSR_CLOSED) begin
            // tracking keeps the handover into closed loop bumpless
            loop_drive <= fan_drive;
        end else if (ref_tick) begin
            if (!fast && loop_drive != 8'h00) begin
                loop_drive <= loop_drive - 8'h01;
            end else if (fast && loop_drive != 8'hff) begin
                loop_drive <= loop_drive + 8'h01;
            end
        end
    end

    always_comb begin
        case (cfg.mode)
            fsr_pkg::FSR_FULL_ON: next_drive = fsr_pkg::DRIVE_FULL_ON;
            fsr_pkg::FSR_FULL_OFF: next_drive = fsr_pkg::DRIVE_FULL_OFF;
            fsr_pkg::FSR_CLOSED: next_drive = loop_drive;
            fsr_pkg::FSR_OPEN: next_drive = dac;
            default: next_drive = fsr_pkg::DRIVE_FULL_ON;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fan_drive <= fsr_pkg::DRIVE_FULL_ON;
        end else begin
            fan_drive <= next_drive;
        end
    end

    // ---- tach pulse counter over a programmable interval
    assign ivl_len = 32'(COUNT_BASE) << count_time;
    assign ivl_end = (ivl_cnt >= ivl_len - 32'h1);
    assign next_tach = (tach_rise && tach_cnt != fsr_pkg::TACH_MAX) ?
        tach_cnt + 8'h01 : tach_cnt;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ivl_cnt <= 32'h0000_0000;
            tach_cnt <= 8'h00;
            tach_reg <= 8'h00;
        end else if (ivl_end) begin
            ivl_cnt <= 32'h0000_0000;
            tach_cnt <= 8'h00;
            tach_reg <= next_tach;
        end else begin
            ivl_cnt <= ivl_cnt + 32'h1;
            tach_cnt <= next_tach;
        end
    end

    // sticky overflow, cleared by writing one; a new overflow beats the clear
    assign ovf_set = (next_tach == fsr_pkg::TACH_MAX) && tach_rise;
    assign ovf_clr = wr_lane && (aw_addr == fsr_pkg::REG_ALARM_STATUS) &&
        w_data[fsr_pkg::ALARM_OVF_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovf_flag <= 1'b0;
            tach_overflow_alert <= 1'b0;
        end else begin
            ovf_flag <= ovf_set || (ovf_flag && !ovf_clr);
            tach_overflow_alert <= ovf_flag && alarm_en_ovf;
        end
    end

    // ---- open-drain general pins: pins 0-2 two-bit codes, 3-4 one bit
    assign general_pin_drive = 5'h00;

    for (genvar i = 0; i < fsr_pkg::NUM_PINS; i++) begin : g_pin
        logic low;
        assign pin_present[i] = MULTI_TACH || (i < fsr_pkg::NUM_PINS_SINGLE);
        if (i < fsr_pkg::NUM_PAIR_PINS) begin : g_pair
            assign low = (gpio_def[2*i+1 -: 2] == 2'b10);
        end else begin : g_single
            assign low = !gpio_def[fsr_pkg::NUM_PAIR_PINS + i];
        end
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                general_pin_oe[i] <= 1'b0;
            end else begin
                general_pin_oe[i] <= low && pin_present[i];
            end
        end
    end

    // ---- checks
    full_on_drive_a: assert property (
        (cfg.mode == fsr_pkg::FSR_FULL_ON) [*2] |-> fan_drive == 8'h00)
        else $error("full-on mode did not give drive 00h");
    full_off_drive_a: assert property (
        (cfg.mode == fsr_pkg::FSR_FULL_OFF) [*2] |-> fan_drive == 8'hff)
        else $error("full-off mode did not give drive ffh");
    open_loop_dac_a: assert property (
        cfg.mode == fsr_pkg::FSR_OPEN |=> fan_drive == $past(dac))
        else $error("open-loop drive differs from dac register");
    slow_raises_a: assert property (
        cfg.mode == fsr_pkg::FSR_CLOSED && ref_tick && !fast && loop_drive != 8'h00
        |=> loop_drive == $past(loop_drive) - 8'h01)
        else $error("slow fan did not raise drive by one step");
    fast_lowers_a: assert property (
        cfg.mode == fsr_pkg::FSR_CLOSED && ref_tick && fast && loop_drive != 8'hff
        |=> loop_drive == $past(loop_drive) + 8'h01)
        else $error("fast fan did not lower drive by one step");
    loop_holds_a: assert property (
        cfg.mode == fsr_pkg::FSR_CLOSED && !ref_tick |=> $stable(loop_drive))
        else $error("loop drive moved without a comparison");
    closed_follows_a: assert property (
        (cfg.mode == fsr_pkg::FSR_CLOSED) [*2] |-> fan_drive == $past(loop_drive))
        else $error("closed-loop drive not applied");
    base_tick_a: assert property (
        base_tick |=> !base_tick [*8])
        else $error("base ticks too close together");
    ref_period_a: assert property (
        ref_tick |-> base_tick && ref_cnt >= speed)
        else $error("reference tick outside base tick");
    tach_sat_a: assert property (
        !ivl_end && tach_cnt == 8'hff |=> tach_cnt == 8'hff || $past(ivl_end))
        else $error("tach counter left saturation");
    tach_latch_a: assert property (
        ivl_end |=> tach_reg == $past(next_tach) && tach_cnt == 8'h00)
        else $error("interval end did not latch and restart");
    pin_low_a: assert property (
        gpio_def.pin_zero == 2'b10 |=> general_pin_oe[0] && !general_pin_drive[0])
        else $error("pin zero not driven low");
    pin_high_a: assert property (
        gpio_def.pin_three |=> !general_pin_oe[3])
        else $error("pin three not released");
    ovf_sticky_a: assert property (
        ovf_set |=> ovf_flag)
        else $error("overflow not recorded");
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before ready");

    closed_step_c: cover property (cfg.mode == fsr_pkg::FSR_CLOSED && ref_tick);
    tach_sat_c: cover property (ivl_end && next_tach == 8'hff);
    write_done_c: cover property (wr_fire && wr_hit);
    pin_low_c: cover property (general_pin_oe[4]);

endmodule : fsr_core

// >>> sim/fsr_fan_model.sv
// Far side of the regulator: a fan tachometer and the board around the
// general pins (internal pull-ups, an external part that can pull low).
// Assumes the bench sets run, the tach half period and the pull-low mask.
`timescale 1ns/1ps
module fsr_fan_model (
    // control from the bench
    input wire logic run,
    input wire logic [31:0] half_ns,
    input wire logic [4:0] ext_low,
    // pins of the regulator
    input wire logic [4:0] oe,
    output logic tach,
    output logic [4:0] level
);
    // a stopped fan leaves the tach line low, it gives no pulses;
    // run starts low, so this one process also sets the initial level
    always begin
        if (run) begin
            #(half_ns) tach = ~tach;
        end else begin
            tach = 1'b0;
            #10;
        end
    end

    // open drain with pull-up: low if either side pulls
    assign level = ~(oe | ext_low);
endmodule : fsr_fan_model

// >>> sim/tb_fan_speed_regulator_core.sv
// Self-checking bench for the regulator core: registers over AXI4-Lite,
// drive modes, general pins, tach counting and the closed loop.
// Assumes shortened counts: OSC_DIV 2, COUNT_BASE 100 cycles.
`timescale 1ns/1ps
`define CK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin num_errors++; \
    $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module tb_fan_speed_regulator_core;
    logic aclk = 0, aresetn = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, tach, alert, run = 0;
    logic [1:0] bresp, rresp, r;
    logic [7:0] drive;
    logic [4:0] lvl, pdrv, oe, ext_low = 0;
    int half_ns = 160, num_errors = 0, checked = 0;

    always #20 aclk = ~aclk;

    fsr_core #(.OSC_DIV(2), .COUNT_BASE(100), .MULTI_TACH(1'b1)) uut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .primary_tach_input(tach), .fan_drive(drive), .tach_overflow_alert(alert),
        .general_pin_level(lvl), .general_pin_drive(pdrv), .general_pin_oe(oe));

    fsr_fan_model fan (.run(run), .half_ns(half_ns), .ext_low(ext_low), .oe(oe),
        .tach(tach), .level(lvl));

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc

    task automatic conclude();
        if (num_errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] s);
        int n;
        awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bvalid) break;
        end
        s = bresp;
        if (n == 50) begin
            num_errors++;
            conclude();
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
        int n;
        araddr <= a; arvalid <= 1; rready <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 0;
            if (rvalid) break;
        end
        v = rdata;
        s = rresp;
        if (n == 50) begin
            num_errors++;
            conclude();
        end
    endtask : rd

    // phase of the internal dividers is unknown, so some checks take a window
    task automatic in_rng(input string nm, input logic [31:0] v, input logic [31:0] lo, hi);
        `CK(nm, 1'b1, (v >= lo && v <= hi))
    endtask : in_rng

    initial begin
        cyc(3);
        aresetn <= 1;
        cyc(1);
        rd(8'h04, d, r); `CK("config reset", 32'h0, d)
        rd(8'h0c, d, r); `CK("pin def reset", 32'hff, d)
        `CK("pin oe reset", 5'h00, oe)
        `CK("drive full on", 8'h00, drive)
        rd(8'h14, d, r); `CK("count time reset", 32'h3, d)
        wr(8'h3c, 32'h1, r); `CK("unmapped write", 2'h2, r)
        rd(8'h3c, d, r); `CK("unmapped read", 2'h2, r)
        wr(8'h00, 32'h1ff, r); `CK("write okay", 2'h0, r)
        rd(8'h00, d, r); `CK("speed", 32'hff, d)
        wr(8'h04, 32'h10, r); cyc(2); `CK("drive full off", 8'hff, drive)
        wr(8'h08, 32'h5a, r); wr(8'h04, 32'h30, r);
        cyc(2); `CK("drive open loop", 8'h5a, drive)
        wr(8'h0c, 32'hae, r); cyc(2); `CK("pins driven low", 5'b01101, oe)
        `CK("pin drive level", 5'h00, pdrv)
        ext_low <= 5'h10;
        cyc(4); rd(8'h10, d, r); `CK("pin status", 32'h02, d)
        wr(8'h0c, 32'hff, r); ext_low <= 0;
        cyc(2); `CK("pins released", 5'h00, oe)
        run <= 1;
        wr(8'h04, 32'h34, r);
        wr(8'h14, 32'h0, r);
        cyc(250); rd(8'h18, d, r); in_rng("tach raw count", d, 11, 14);
        half_ns <= 50;
        wr(8'h1c, 32'h4, r); wr(8'h14, 32'h3, r);
        cyc(1800); rd(8'h18, d, r); `CK("tach saturated", 32'hff, d)
        `CK("overflow alert", 1'b1, alert)
        run <= 0;
        wr(8'h04, 32'h10, r); wr(8'h00, 32'h2, r);
        wr(8'h04, 32'h20, r);
        cyc(1700); in_rng("stalled fan drive", drive, 8'hfc, 8'hfe);
        wr(8'h04, 32'h10, r); wr(8'h04, 32'h00, r);
        half_ns <= 160; run <= 1;
        cyc(20); wr(8'h00, 32'h0, r); wr(8'h04, 32'h22, r);
        cyc(800); in_rng("fast fan drive", drive, 8'h01, 8'h04);
        conclude();
    end
endmodule : tb_fan_speed_regulator_core
